// [inc/spe_map_pkg.sv]
/*
 constants for the ds3 to sts-1 envelope mapper and demapper:
 envelope geometry, column roles, bit positions inside control bytes,
 reservoir sizing and the mapper state codes.
 assumes the envelope side delivers and accepts bytes in transmission
 order, most significant bit first.
*/
package spe_map_pkg;

	// envelope geometry
	localparam int COLS = 87;
	localparam int ROWS = 9;
	localparam logic [6:0] LAST_COL = 7'h56;
	localparam logic [3:0] LAST_ROW = 4'h8;
	localparam logic [6:0] POH_COL = 7'h00;

	// column roles inside one row
	localparam logic [6:0] C1_COL = 7'h03;
	localparam logic [6:0] C2_COL = 7'h1F;
	localparam logic [6:0] C3_COL = 7'h3C;
	localparam logic [6:0] R_COL_A = 7'h01;
	localparam logic [6:0] R_COL_B = 7'h02;
	localparam logic [6:0] R_COL_C = 7'h1D;
	localparam logic [6:0] R_COL_D = 7'h1E;
	localparam logic [6:0] R_COL_E = 7'h3A;
	localparam logic [6:0] R_COL_F = 7'h3B;

	// bit positions, msb sent first
	localparam int C1_CTRL_BIT = 5;
	localparam int C23_CTRL_HI = 7;
	localparam int C23_CTRL_LO = 6;
	localparam int C3_OH_HI = 3;
	localparam int C3_OH_LO = 2;
	localparam int C3_OPP_BIT = 0;

	// data bits carried per byte kind
	localparam logic [3:0] NEED_I = 4'h8;
	localparam logic [3:0] NEED_C1 = 4'h5;
	localparam logic [3:0] NEED_OPP = 4'h1;
	localparam logic [3:0] NEED_NONE = 4'h0;

	// value sent in fixed stuff positions
	localparam logic [7:0] FILL_BYTE = 8'h00;

	// bit reservoir of the mapper, control vote thresholds of the demapper
	localparam int RES_W = 32;
	localparam logic [5:0] RES_FULL = 6'h20;
	localparam logic [5:0] STUFF_LEVEL = 6'h10;
	localparam logic [2:0] VOTE_MAJ = 3'h3;
	localparam logic [2:0] VOTE_ALL = 3'h5;

	// two-entry output buffer width: start flag and byte
	localparam int BUF_W = 9;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FILL = 3'b010,
		ST_RUN = 3'b100
	} map_state_e;

endpackage

// [src/two_slot_buf.sv]
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock; both ready and valid come from flip-flops, so a
 stall on the drain side reaches the fill side one cycle later without
 losing a word.
*/
module two_slot_buf #(
	parameter int W = 9
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);

	logic [W-1:0] head_q;
	logic [W-1:0] tail_q;
	logic head_v_q;
	logic tail_v_q;
	wire push = in_valid_i & ~tail_v_q;
	wire pop = head_v_q & out_ready_i;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			head_q <= '0;
			tail_q <= '0;
			head_v_q <= 1'b0;
			tail_v_q <= 1'b0;
		end else if (pop) begin
			if (tail_v_q) begin
				head_q <= tail_q;
				tail_v_q <= 1'b0;
			end else begin
				head_q <= in_data_i;
				head_v_q <= push;
			end
		end else if (push) begin
			if (!head_v_q) begin
				head_q <= in_data_i;
				head_v_q <= 1'b1;
			end else begin
				tail_q <= in_data_i;
				tail_v_q <= 1'b1;
			end
		end
	end

	assign in_ready_o = ~tail_v_q;
	assign out_data_o = head_q;
	assign out_valid_o = head_v_q;

endmodule

// [src/ds3_spe_mapper.sv]
/*
 bit-level asynchronous mapping of a ds3 bit stream into the sts-1
 payload envelope, and extraction of ds3 bits from a received envelope.
 assumes the envelope side tracks pointers and marks the first (path
 overhead) byte of each envelope; frame boundaries are not seen here.
*/
module ds3_spe_mapper (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic ds3_tx_bit_i,
	input wire logic ds3_tx_valid_i,
	output logic ds3_tx_ready_o,
	input wire logic [7:0] poh_tx_i,
	input wire logic [1:0] oh_tx_i,
	output logic [7:0] spe_tx_byte_o,
	output logic spe_tx_start_o,
	output logic spe_tx_valid_o,
	input wire logic spe_tx_ready_i,
	input wire logic [7:0] spe_rx_byte_i,
	input wire logic spe_rx_start_i,
	input wire logic spe_rx_valid_i,
	output logic spe_rx_ready_o,
	output logic [7:0] ds3_rx_bits_o,
	output logic [3:0] ds3_rx_count_o,
	output logic ds3_rx_valid_o,
	input wire logic ds3_rx_ready_i,
	output logic [7:0] poh_rx_o,
	output logic poh_rx_stb_o,
	output logic [1:0] oh_rx_o,
	output logic oh_rx_stb_o,
	output logic ctrl_err_o
);

	// ---------------- mapper ----------------
	spe_map_pkg::map_state_e st_q;
	spe_map_pkg::map_state_e st_d;
	logic [6:0] tcol_q;
	logic [3:0] trow_q;
	logic [spe_map_pkg::RES_W-1:0] res_q;
	logic [spe_map_pkg::RES_W-1:0] res_d;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic opp_data_q;
	logic tx_ready_q;
	logic buf_ready;

	// envelope position; counting envelope bytes only lets it straddle frames
	wire t_poh = tcol_q == spe_map_pkg::POH_COL;
	wire t_c1 = tcol_q == spe_map_pkg::C1_COL;
	wire t_c2 = tcol_q == spe_map_pkg::C2_COL;
	wire t_c3 = tcol_q == spe_map_pkg::C3_COL;
	wire t_r = tcol_q == spe_map_pkg::R_COL_A || tcol_q == spe_map_pkg::R_COL_B ||
		tcol_q == spe_map_pkg::R_COL_C || tcol_q == spe_map_pkg::R_COL_D ||
		tcol_q == spe_map_pkg::R_COL_E || tcol_q == spe_map_pkg::R_COL_F;
	wire t_i = ~(t_poh | t_c1 | t_c2 | t_c3 | t_r);

	// stuff decision at the row's first control byte: a deep reservoir means
	// ds3 runs ahead, so the opportunity takes data
	wire opp_now = cnt_q >= spe_map_pkg::STUFF_LEVEL;
	wire opp_data = t_c1 ? opp_now : opp_data_q;
	wire cbit = ~opp_data;
	wire [3:0] need = t_i ? spe_map_pkg::NEED_I :
		t_c1 ? spe_map_pkg::NEED_C1 :
		(t_c3 && opp_data) ? spe_map_pkg::NEED_OPP : spe_map_pkg::NEED_NONE;
	wire gen = st_q == spe_map_pkg::ST_RUN && buf_ready && cnt_q >= {2'b00, need};
	wire push_bit = ds3_tx_valid_i & tx_ready_q;
	wire [7:0] top = res_q[spe_map_pkg::RES_W-1 -: 8];

	logic [7:0] tx_byte;
	always_comb begin
		tx_byte = top;
		if (t_poh)
			tx_byte = poh_tx_i;
		else if (t_r)
			tx_byte = spe_map_pkg::FILL_BYTE;
		else if (t_c1)
			tx_byte = {2'b00, cbit, top[7:3]};
		else if (t_c2)
			tx_byte = {cbit, cbit, 6'h00};
		else if (t_c3)
			tx_byte = {cbit, cbit, 2'b00, oh_tx_i, 1'b0, opp_data & top[7]};
	end

	// reservoir: oldest bit at the top, consumed bits shift out
	always_comb begin
		logic [5:0] left;
		left = cnt_q - (gen ? {2'b00, need} : 6'h00);
		res_d = gen ? res_q << need : res_q;
		if (push_bit)
			res_d[5'(spe_map_pkg::RES_W - 1) - left[4:0]] = ds3_tx_bit_i;
		cnt_d = left + {5'h00, push_bit};
	end

	always_comb begin
		case (st_q)
			spe_map_pkg::ST_IDLE: st_d = en_i ? spe_map_pkg::ST_FILL : spe_map_pkg::ST_IDLE;
			spe_map_pkg::ST_FILL: st_d = !en_i ? spe_map_pkg::ST_IDLE :
				opp_now ? spe_map_pkg::ST_RUN : spe_map_pkg::ST_FILL;
			spe_map_pkg::ST_RUN: st_d = en_i ? spe_map_pkg::ST_RUN : spe_map_pkg::ST_IDLE;
			default: st_d = spe_map_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= spe_map_pkg::ST_IDLE;
			res_q <= '0;
			cnt_q <= 6'h00;
			tx_ready_q <= 1'b0;
		end else begin
			st_q <= st_d;
			res_q <= res_d;
			cnt_q <= cnt_d;
			tx_ready_q <= cnt_d < spe_map_pkg::RES_FULL;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tcol_q <= 7'h00;
			trow_q <= 4'h0;
			opp_data_q <= 1'b0;
		end else if (st_q == spe_map_pkg::ST_IDLE) begin
			tcol_q <= 7'h00;
			trow_q <= 4'h0;
		end else if (gen) begin
			if (t_c1)
				opp_data_q <= opp_now;
			if (tcol_q == spe_map_pkg::LAST_COL) begin
				tcol_q <= 7'h00;
				trow_q <= (trow_q == spe_map_pkg::LAST_ROW) ? 4'h0 : trow_q + 4'h1;
			end else begin
				tcol_q <= tcol_q + 7'h01;
			end
		end
	end

	wire tx_start = t_poh && trow_q == 4'h0;
	wire [spe_map_pkg::BUF_W-1:0] buf_out;

	// a stall by the envelope side holds the generator, never drops a byte
	two_slot_buf #(
		.W(spe_map_pkg::BUF_W)
	) u_tx_buf (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_data_i({tx_start, tx_byte}),
		.in_valid_i(gen),
		.in_ready_o(buf_ready),
		.out_data_o(buf_out),
		.out_valid_o(spe_tx_valid_o),
		.out_ready_i(spe_tx_ready_i)
	);

	assign spe_tx_start_o = buf_out[8];
	assign spe_tx_byte_o = buf_out[7:0];
	assign ds3_tx_ready_o = tx_ready_q;

	// ---------------- demapper ----------------
	logic [6:0] rcol_q;
	logic locked_q;
	logic c1_q;
	logic [1:0] c2_q;
	logic rx_ready_q;
	logic [7:0] rbits_q;
	logic [3:0] rcount_q;
	logic rvalid_q;
	logic [7:0] poh_q;
	logic poh_stb_q;
	logic [1:0] oh_q;
	logic oh_stb_q;
	logic err_q;

	wire take = spe_rx_valid_i & rx_ready_q & (locked_q | spe_rx_start_i);
	wire [6:0] rcol = spe_rx_start_i ? spe_map_pkg::POH_COL : rcol_q;
	wire [7:0] b = spe_rx_byte_i;
	wire r_poh = rcol == spe_map_pkg::POH_COL;
	wire r_c1 = rcol == spe_map_pkg::C1_COL;
	wire r_c2 = rcol == spe_map_pkg::C2_COL;
	wire r_c3 = rcol == spe_map_pkg::C3_COL;
	wire r_r = rcol == spe_map_pkg::R_COL_A || rcol == spe_map_pkg::R_COL_B ||
		rcol == spe_map_pkg::R_COL_C || rcol == spe_map_pkg::R_COL_D ||
		rcol == spe_map_pkg::R_COL_E || rcol == spe_map_pkg::R_COL_F;
	wire r_i = ~(r_poh | r_c1 | r_c2 | r_c3 | r_r);
	wire [2:0] ones = {2'b00, c1_q} + {2'b00, c2_q[1]} + {2'b00, c2_q[0]} +
		{2'b00, b[spe_map_pkg::C23_CTRL_HI]} + {2'b00, b[spe_map_pkg::C23_CTRL_LO]};
	wire opp_stuff = ones >= spe_map_pkg::VOTE_MAJ;
	wire vote_split = ones != 3'h0 && ones != spe_map_pkg::VOTE_ALL;
	wire emit = take && (r_i || r_c1 || (r_c3 && !opp_stuff));
	wire [7:0] ebits = r_c1 ? {b[4:0], 3'h0} : r_c3 ? {b[spe_map_pkg::C3_OPP_BIT], 7'h00} : b;
	wire [3:0] ecount = r_c1 ? spe_map_pkg::NEED_C1 : r_c3 ? spe_map_pkg::NEED_OPP :
		spe_map_pkg::NEED_I;
	wire rvalid_d = emit | (rvalid_q & ~ds3_rx_ready_i);

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rcol_q <= 7'h00;
			locked_q <= 1'b0;
			c1_q <= 1'b0;
			c2_q <= 2'b00;
		end else if (take) begin
			locked_q <= 1'b1;
			if (r_c1)
				c1_q <= b[spe_map_pkg::C1_CTRL_BIT];
			if (r_c2)
				c2_q <= b[spe_map_pkg::C23_CTRL_HI:spe_map_pkg::C23_CTRL_LO];
			if (rcol == spe_map_pkg::LAST_COL) begin
				rcol_q <= 7'h00;
			end else begin
				rcol_q <= rcol + 7'h01;
			end
		end
	end

	// ready waits for the output word to drain; half rate is ample for sts-1
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rbits_q <= 8'h00;
			rcount_q <= 4'h0;
			rvalid_q <= 1'b0;
			rx_ready_q <= 1'b0;
			poh_q <= 8'h00;
			poh_stb_q <= 1'b0;
			oh_q <= 2'b00;
			oh_stb_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			rvalid_q <= rvalid_d;
			rx_ready_q <= ~rvalid_d;
			if (emit) begin
				rbits_q <= ebits;
				rcount_q <= ecount;
			end
			poh_stb_q <= take & r_poh;
			if (take & r_poh)
				poh_q <= b;
			oh_stb_q <= take & r_c3;
			if (take & r_c3)
				oh_q <= b[spe_map_pkg::C3_OH_HI:spe_map_pkg::C3_OH_LO];
			err_q <= take & r_c3 & vote_split;
		end
	end

	assign spe_rx_ready_o = rx_ready_q;
	assign ds3_rx_bits_o = rbits_q;
	assign ds3_rx_count_o = rcount_q;
	assign ds3_rx_valid_o = rvalid_q;
	assign poh_rx_o = poh_q;
	assign poh_rx_stb_o = poh_stb_q;
	assign oh_rx_o = oh_q;
	assign oh_rx_stb_o = oh_stb_q;
	assign ctrl_err_o = err_q;

endmodule

// [verif/ds3_spe_mapper_properties.sv]
/* port assertions for the envelope mapper.
 assumes start marks column 0 of row 0 and bytes leave in envelope order. */
module ds3_spe_mapper_properties (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] spe_tx_byte_o,
	input wire logic spe_tx_start_o,
	input wire logic spe_tx_valid_o,
	input wire logic spe_tx_ready_i,
	input wire logic [7:0] spe_rx_byte_i,
	input wire logic spe_rx_start_i,
	input wire logic spe_rx_valid_i,
	input wire logic spe_rx_ready_o,
	input wire logic [3:0] ds3_rx_count_o,
	input wire logic ds3_rx_valid_o,
	input wire logic [7:0] ds3_rx_bits_o,
	input wire logic ds3_rx_ready_i,
	input wire logic [7:0] poh_rx_o,
	input wire logic poh_rx_stb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [6:0] col_q;
	logic [3:0] row_q;
	logic seen_q, c1_q;
	wire take = spe_tx_valid_o && spe_tx_ready_i;
	wire [6:0] cur = spe_tx_start_o ? 7'h00 : col_q;
	wire wrap = cur == spe_map_pkg::LAST_COL;
	wire is_r = cur == spe_map_pkg::R_COL_A || cur == spe_map_pkg::R_COL_B
		|| cur == spe_map_pkg::R_COL_C || cur == spe_map_pkg::R_COL_D
		|| cur == spe_map_pkg::R_COL_E || cur == spe_map_pkg::R_COL_F;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			col_q <= 7'h00;
			row_q <= 4'h0;
			seen_q <= 1'b0;
			c1_q <= 1'b0;
		end else if (take) begin
			col_q <= wrap ? 7'h00 : cur + 7'h01;
			row_q <= (spe_tx_start_o || (wrap && row_q == spe_map_pkg::LAST_ROW)) ? 4'h0
				: row_q + {3'h0, wrap};
			seen_q <= 1'b1;
			c1_q <= (cur == spe_map_pkg::C1_COL) ? spe_tx_byte_o[5] : c1_q;
		end
	end
	sequence tx_stall_s;
		spe_tx_valid_o && !spe_tx_ready_i;
	endsequence
	sequence poh_take_s;
		spe_rx_valid_i && spe_rx_ready_o && spe_rx_start_i;
	endsequence
	fill_zero_a: assert property (take && is_r |-> spe_tx_byte_o == 8'h00)
		else $error("fixed stuff byte not zero");
	start_place_a: assert property (take && spe_tx_start_o && seen_q |-> {col_q, row_q} == 11'h0)
		else $error("envelope start out of place");
	c1_form_a: assert property (take && cur == spe_map_pkg::C1_COL |-> spe_tx_byte_o[7:6] == 2'h0)
		else $error("first control byte malformed");
	c2_ctrl_a: assert property (take && cur == spe_map_pkg::C2_COL |-> spe_tx_byte_o == {{2{c1_q}}, 6'h00})
		else $error("second control byte disagrees");
	c3_ctrl_a: assert property (take && cur == spe_map_pkg::C3_COL |->
		spe_tx_byte_o[7:4] == {{2{c1_q}}, 2'h0} && !spe_tx_byte_o[1])
		else $error("third control byte malformed");
	opp_stuff_a: assert property (take && cur == spe_map_pkg::C3_COL && c1_q |-> !spe_tx_byte_o[0])
		else $error("stuffed opportunity not zero");
	tx_hold_a: assert property (tx_stall_s |=> spe_tx_valid_o && $stable(spe_tx_byte_o))
		else $error("stalled byte changed");
	poh_out_a: assert property (poh_take_s |=> poh_rx_stb_o && poh_rx_o == $past(spe_rx_byte_i))
		else $error("path overhead not passed out");
	word_len_a: assert property (ds3_rx_valid_o |-> ds3_rx_count_o inside {4'h8, 4'h5, 4'h1})
		else $error("bad word length");
	rx_hold_a: assert property (ds3_rx_valid_o && !ds3_rx_ready_i |=> ds3_rx_valid_o && $stable(ds3_rx_bits_o))
		else $error("held ds3 word changed");
endmodule

// [verif/env_loop.sv]
/* loopback far end: returns mapper bytes to the demapper.
 assumes the block's clock; flip_i corrupts one control bit per row. */
module env_loop (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	input wire logic flip_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_start_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_byte_o,
	output logic rx_start_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] hold_q;
	logic [6:0] col_q;
	logic full_q, start_q;
	wire [6:0] cur = tx_start_i ? 7'h00 : col_q;
	wire [7:0] err = (flip_i && cur == spe_map_pkg::C1_COL) ? 8'h20 : 8'h00;
	assign tx_ready_o = !full_q && !stall_i;
	assign rx_valid_o = full_q;
	assign rx_start_o = full_q && start_q;
	// released line shows inverted last byte, not a stale copy
	assign rx_byte_o = full_q ? hold_q : ~hold_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			full_q <= 1'b0;
			start_q <= 1'b0;
			hold_q <= 8'h00;
			col_q <= 7'h00;
		end else if (tx_valid_i && tx_ready_o) begin
			full_q <= 1'b1;
			start_q <= tx_start_i;
			hold_q <= tx_byte_i ^ err;
			col_q <= (cur == spe_map_pkg::LAST_COL) ? 7'h00 : cur + 7'h01;
		end else if (rx_ready_i) begin
			full_q <= 1'b0;
		end
	end
endmodule

// [verif/ds3_spe_mapper_tb.sv]
/* self-checking bench: mapper output looped back into the demapper.
 assumes the loopback returns bytes unchanged unless flip is set. */
module ds3_spe_mapper_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, en_i = 1'b0, ds3_tx_bit_i = 1'b0;
	logic ds3_tx_valid_i = 1'b0, ds3_rx_ready_i = 1'b0, stall_i = 1'b0, flip_i = 1'b0;
	logic [7:0] poh_tx_i = 8'hB4;
	logic [1:0] oh_tx_i = 2'h2;
	logic ds3_tx_ready_o, spe_tx_start_o, spe_tx_valid_o, spe_tx_ready_i, spe_rx_start_i;
	logic spe_rx_valid_i, spe_rx_ready_o, ds3_rx_valid_o, poh_rx_stb_o, oh_rx_stb_o, ctrl_err_o;
	logic [7:0] spe_tx_byte_o, spe_rx_byte_i, ds3_rx_bits_o, poh_rx_o;
	logic [3:0] ds3_rx_count_o;
	logic [1:0] oh_rx_o;
	int n_errors = 0, checks_done = 0, rows, n621, n622, n_cerr, rbits = -1, idx = 0, k, cyc = 0;
	bit stall_on = 1'b0;
	bit q[$];
	ds3_spe_mapper u_ds3_spe_mapper (.mclk_i, .rst_n_i, .en_i, .ds3_tx_bit_i, .ds3_tx_valid_i,
		.ds3_tx_ready_o, .poh_tx_i, .oh_tx_i, .spe_tx_byte_o, .spe_tx_start_o, .spe_tx_valid_o,
		.spe_tx_ready_i, .spe_rx_byte_i, .spe_rx_start_i, .spe_rx_valid_i, .spe_rx_ready_o,
		.ds3_rx_bits_o, .ds3_rx_count_o, .ds3_rx_valid_o, .ds3_rx_ready_i, .poh_rx_o,
		.poh_rx_stb_o, .oh_rx_o, .oh_rx_stb_o, .ctrl_err_o);
	env_loop u_env_loop (.clk_i(mclk_i), .rst_n_i, .stall_i, .flip_i, .tx_byte_i(spe_tx_byte_o),
		.tx_start_i(spe_tx_start_o), .tx_valid_i(spe_tx_valid_o), .tx_ready_o(spe_tx_ready_i),
		.rx_byte_o(spe_rx_byte_i), .rx_start_o(spe_rx_start_i), .rx_valid_o(spe_rx_valid_i),
		.rx_ready_i(spe_rx_ready_o));
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %0h got %0h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// bounded wait on rows seen by the demapper
	task automatic wait_rows(input int n);
		int lim;
		lim = n * 3000;
		rows = 0;
		n621 = 0;
		n622 = 0;
		n_cerr = 0;
		while (rows < n && lim > 0) begin
			@(posedge mclk_i);
			lim--;
		end
		if (lim == 0) begin
			n_errors++;
			close_out();
		end
	endtask
	always @(posedge mclk_i) begin
		if (ds3_tx_valid_i && ds3_tx_ready_o) begin
			q.push_back(ds3_tx_bit_i);
			idx = idx + 1;
			ds3_tx_bit_i <= idx[0] ^ idx[2] ^ idx[5];
		end
		// one byte per eight cycles is slower than the bits arrive, so the
		// reservoir fills; a stall tied to the bit count could freeze for good
		cyc++;
		stall_i <= stall_on && cyc % 8 != 0;
		ds3_rx_ready_i <= !(stall_on && cyc % 3 == 0);
		if (ds3_rx_valid_o && ds3_rx_ready_i) begin
			for (k = 0; k < int'(ds3_rx_count_o); k++)
				chk("ds3 bit", {31'h0, q.pop_front()}, {31'h0, ds3_rx_bits_o[7-k]});
			rbits += int'(ds3_rx_count_o);
		end
		if (poh_rx_stb_o) begin
			chk("poh", {24'h0, poh_tx_i}, {24'h0, poh_rx_o});
			if (rbits >= 0) chk("row bits", 32'h1, {31'h0, rbits inside {621, 622}});
			n621 += int'(rbits == 621);
			n622 += int'(rbits == 622);
			rbits = 0;
			rows++;
		end
		if (oh_rx_stb_o) chk("oh bits", {30'h0, oh_tx_i}, {30'h0, oh_rx_o});
		n_cerr += int'(ctrl_err_o);
	end
	task automatic test_free();
		wait_rows(10);
		chk("stuffed rows", 32'h1, {31'h0, n621 > 0});
		chk("split votes", 32'h0, {31'h0, n_cerr > 0});
		$display("test free done");
	endtask
	task automatic test_stall();
		stall_on = 1'b1;
		wait_rows(10);
		chk("data rows", 32'h1, {31'h0, n622 > 0});
		stall_on = 1'b0;
		$display("test stall done");
	endtask
	task automatic test_vote();
		flip_i <= 1'b1;
		wait_rows(4);
		chk("split votes", 32'h1, {31'h0, n_cerr > 0});
		flip_i <= 1'b0;
		$display("test vote done");
	endtask
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		en_i <= 1'b1;
		ds3_tx_valid_i <= 1'b1;
		test_free();
		test_stall();
		test_vote();
		close_out();
	end
endmodule
bind ds3_spe_mapper ds3_spe_mapper_properties u_props (.mclk_i, .rst_n_i, .spe_tx_byte_o,
	.spe_tx_start_o, .spe_tx_valid_o, .spe_tx_ready_i, .spe_rx_byte_i, .spe_rx_start_i,
	.spe_rx_valid_i, .spe_rx_ready_o, .ds3_rx_count_o, .ds3_rx_valid_o, .ds3_rx_bits_o,
	.ds3_rx_ready_i, .poh_rx_o, .poh_rx_stb_o);
